// file: src/pcg_pkg.sv
// Package of register map, field positions and reset values for the port C output control block
package pcg_pkg;
   // Register byte offsets on APB (one aligned word each)
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_DIRECTION = 8'h04;
   localparam logic [7:0] ADDR_SLEW = 8'h08;
   localparam logic [7:0] ADDR_DRIVE = 8'h0c;
   localparam logic [7:0] ADDR_GANG = 8'h10;
   localparam logic [7:0] ADDR_GANG_STATUS = 8'h14;
   // Field positions in the ganged control register
   localparam int GANG_EN_BIT = 0;
   localparam int GANG_SEL_LSB = 1;
   // Reset values
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_SLEW = 8'h00;
   localparam logic [7:0] RST_DRIVE = 8'h00;
   localparam logic [7:0] RST_GANG = 8'h00;
   localparam logic [7:0] RST_PAD_OE_N = 8'hff;
   // Control registers written by software
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] direction;
      logic [7:0] slew;
      logic [7:0] drive;
      logic [7:0] gang;
      logic gang_written;
   } pcg_regs_t;
   // Per-pin controls presented to the pad ring
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] slew;
      logic [7:0] drive;
   } pcg_pad_t;
endpackage

// file: src/pcg_port_c.sv
// Port C output control with slew, drive strength and write-once ganged drive, APB slave
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Slew enable per pin, outputs only
// - Drive strength select per pin, outputs only
// - Gang pin selects 7:1 are write-once
// - Ganged pins copy pin zero settings
// - Gang select acts only when enabled
// - Gang enable is write-once bit zero
// - Gang enable forces pin zero output
// - Direction enables driver; reads select source
module pcg_port_c (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   output logic [7:0] pin_slew,
   output logic [7:0] pin_drive
);
   // Reset release and pin synchronisers
   logic rst_sync1_reg;
   logic rst_sync2_reg;
   logic srst_n;
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;
   // Software-visible state and the pad flops that follow it
   pcg_pkg::pcg_regs_t regs_reg;
   pcg_pkg::pcg_regs_t regs_next;
   pcg_pkg::pcg_pad_t pad_reg;
   pcg_pkg::pcg_pad_t pad_next;
   // Bus response flops
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   // Bus phase and address decode
   logic setup;
   logic access;
   logic hit;
   logic [31:0] read_word;
   // Gang decode
   logic gang_on;
   logic [7:0] gang_mask;
   logic [7:0] eff_dir;

   // Reset release is synchronised so every flop on srst_n leaves reset on the same edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   assign srst_n = rst_sync2_reg;

   // Pin levels come from the board, so two flops before any reader
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
      end else begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Zero-wait slave: pready is a constant, so every access ends in its first cycle
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;
   // Read data and error are loaded at the edge that ends the setup cycle, so both already
   // stand from flops when the master samples pready high in the access cycle
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // Gang decode shared by pads and read-back
   assign gang_on = regs_reg.gang[pcg_pkg::GANG_EN_BIT];
   assign gang_mask = gang_on ? {regs_reg.gang[7:pcg_pkg::GANG_SEL_LSB], 1'b0} : 8'h00;
   assign eff_dir = regs_reg.direction | gang_mask | {7'h00, gang_on};

   // Address decode and read mux; only the aligned words of the map answer
   always_comb begin
      hit = 1'b1;
      read_word = 32'h00000000;
      case (paddr)
         pcg_pkg::ADDR_DATA: begin
            // Output pins return the latch, input pins the synchronised pin level
            read_word[7:0] = (regs_reg.data & eff_dir) | (pin_sync_reg & ~eff_dir);
         end
         pcg_pkg::ADDR_DIRECTION: begin
            read_word[7:0] = regs_reg.direction;
         end
         pcg_pkg::ADDR_SLEW: begin
            read_word[7:0] = regs_reg.slew;
         end
         pcg_pkg::ADDR_DRIVE: begin
            read_word[7:0] = regs_reg.drive;
         end
         pcg_pkg::ADDR_GANG: begin
            read_word[7:0] = regs_reg.gang;
         end
         pcg_pkg::ADDR_GANG_STATUS: begin
            // Lock flag above the effective mask, so software can tell whether its write landed
            read_word[8] = regs_reg.gang_written;
            read_word[7:0] = gang_mask;
         end
         default: begin
            // Unmapped or unaligned word: reads zero and is refused
            hit = 1'b0;
         end
      endcase
   end

   // Bus response; the refusal depends on the address alone, so it is known in the setup cycle
   always_comb begin
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      if (setup) begin
         pslverr_next = !hit;
         // Writes leave the last read data in place
         if (!pwrite) begin
            prdata_next = read_word;
         end
      end
   end

   // Register writes land at the access edge, the one at which pready is sampled high
   always_comb begin
      regs_next = regs_reg;
      if (access && pwrite) begin
         case (paddr)
            pcg_pkg::ADDR_DATA: begin
               regs_next.data = pwdata[7:0];
            end
            pcg_pkg::ADDR_DIRECTION: begin
               regs_next.direction = pwdata[7:0];
            end
            pcg_pkg::ADDR_SLEW: begin
               regs_next.slew = pwdata[7:0];
            end
            pcg_pkg::ADDR_DRIVE: begin
               regs_next.drive = pwdata[7:0];
            end
            pcg_pkg::ADDR_GANG: begin
               // Only the first write after reset lands, locking selects and enable together;
               // software cannot stage the selects first, which is the price of a single lock
               if (!regs_reg.gang_written) begin
                  regs_next.gang = pwdata[7:0];
                  regs_next.gang_written = 1'b1;
               end
            end
            default: begin
               // Status is read-only and unmapped writes are dropped
               regs_next = regs_reg;
            end
         endcase
      end
   end

   // Pad controls; slew and drive of input pins are parked low since they have no effect
   // Ganged pins are forced to output, so their copied slew and drive always act
   always_comb begin
      pad_next.oe_n = ~eff_dir;
      for (int i = 0; i < 8; i++) begin
         if (gang_mask[i]) begin
            pad_next.out[i] = regs_reg.data[0];
            pad_next.slew[i] = regs_reg.slew[0];
            pad_next.drive[i] = regs_reg.drive[0];
         end else begin
            pad_next.out[i] = regs_reg.data[i];
            pad_next.slew[i] = regs_reg.slew[i] & eff_dir[i];
            pad_next.drive[i] = regs_reg.drive[i] & eff_dir[i];
         end
      end
   end

   // Register state
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         regs_reg <= '{data: pcg_pkg::RST_DATA, direction: pcg_pkg::RST_DIRECTION,
            slew: pcg_pkg::RST_SLEW, drive: pcg_pkg::RST_DRIVE, gang: pcg_pkg::RST_GANG,
            gang_written: 1'b0};
      end else begin
         regs_reg <= regs_next;
      end
   end

   // Pads lag the registers by one clock; from flops, so no decode glitch reaches a pin
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pad_reg <= '{out: pcg_pkg::RST_DATA, oe_n: pcg_pkg::RST_PAD_OE_N, slew: pcg_pkg::RST_SLEW,
            drive: pcg_pkg::RST_DRIVE};
      end else begin
         pad_reg <= pad_next;
      end
   end

   // Bus response
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign pin_out = pad_reg.out;
   assign pin_oe_n = pad_reg.oe_n;
   assign pin_slew = pad_reg.slew;
   assign pin_drive = pad_reg.drive;
endmodule
`default_nettype wire

// file: tb/pcg_port_c_monitor.sv
// Checker of the port C control block's port behaviour
`timescale 1ns/1ps
`default_nettype none
module pcg_port_c_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pin_slew,
   input wire logic [7:0] pin_drive
);
   // One domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic acc = psel && penable;
   wire logic rd_setup = psel && !penable && !pwrite;
   AST_RDY: assert property (pready) else $error("pready low");
   AST_SLEW: assert property ((pin_slew & pin_oe_n) == 8'h00) else $error("slew on input pin");
   AST_DRV: assert property ((pin_drive & pin_oe_n) == 8'h00) else $error("drive on input pin");
   // Read data and error stand in the access cycle, where the master takes them
   AST_BAD: assert property (acc && !pwrite && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   AST_OK: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
   AST_UPPER: assert property (acc && !pwrite |-> prdata[31:9] == 23'h0) else $error("upper read bits set");
   AST_HOLD: assert property (!rd_setup |=> $stable(prdata)) else $error("read data moved");
   AST_ERR_ACC: assert property (pslverr |-> acc) else $error("error outside access");
   AST_ERR_END: assert property (acc |=> !pslverr) else $error("error held past access");
   // Internal reset lags the pin by two flops, pads stay released meanwhile
   AST_RST: assert property ($rose(rst_n) |-> (pin_oe_n == 8'hff) [*2]) else $error("pin driven in reset");
endmodule
bind pcg_port_c pcg_port_c_monitor u_pcg_port_c_monitor (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .pin_oe_n, .pin_slew, .pin_drive);
`default_nettype wire

// file: tb/pcg_board.sv
// Board side of port C pins
`timescale 1ns/1ps
`default_nettype none
module pcg_board (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] strap,
   output logic [7:0] pin_in
);
   // A driven pin reads back the port's level, a released one the strap
   assign pin_in = (pin_out & ~pin_oe_n) | (strap & pin_oe_n);
endmodule
`default_nettype wire

// file: tb/pcg_port_c_tb.sv
// Self-checking bench of the port C output control block
`timescale 1ns/1ps
`default_nettype none
module pcg_port_c_tb;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [7:0] paddr = 8'h00, pin_in, pin_out, pin_oe_n, pin_slew, pin_drive;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int n_errors = 0, total_checks = 0;
   pcg_port_c u_pcg_port_c (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .pin_in, .pin_out, .pin_oe_n, .pin_slew, .pin_drive);
   pcg_board u_pcg_board (.pin_out, .pin_oe_n, .strap(8'h5a), .pin_in);
   initial forever #50 clk = ~clk;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer; the request is held until pready is seen high
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            // The answer is taken at the edge that completes the access
            rd = prdata;
            er = pslverr;
            break;
         end
      end
      if (k == 16) begin
         n_errors++;
         stop_test;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pins(input logic [7:0] oe, out, sl, dr);
      @(posedge clk);
      #1 chk("oe_n", oe, pin_oe_n);
      chk("out", out, pin_out & ~oe);
      chk("slew", sl, pin_slew);
      chk("drive", dr, pin_drive);
   endtask
   // Reset pulse, then the three edges before the first transfer
   task automatic restart;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic cfg;
      bus(1'b1, pcg_pkg::ADDR_DIRECTION, 8'h12);
      bus(1'b1, pcg_pkg::ADDR_DATA, 8'ha5);
      bus(1'b1, pcg_pkg::ADDR_SLEW, 8'h13);
      bus(1'b1, pcg_pkg::ADDR_DRIVE, 8'h02);
   endtask
   task automatic t_reset;
      pins(8'hff, 8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, pcg_pkg::ADDR_SLEW + 8'(4 * i), 8'h00);
         chk("reset", 8'h00, rd[7:0]);
      end
      bus(1'b0, 8'h40, 8'h00);
      chk("pslverr", 8'h01, {7'h0, er});
      $display("test reset done");
   endtask
   // Selects without the enable leave every pin under its own control
   task automatic t_indiv;
      cfg;
      bus(1'b1, pcg_pkg::ADDR_GANG, 8'h0c);
      pins(8'hed, 8'h00, 8'h12, 8'h02);
      bus(1'b0, pcg_pkg::ADDR_DATA, 8'h00);
      chk("data", 8'h48, rd[7:0]);
      bus(1'b1, pcg_pkg::ADDR_GANG, 8'h0d);
      pins(8'hed, 8'h00, 8'h12, 8'h02);
      bus(1'b0, pcg_pkg::ADDR_GANG, 8'h00);
      chk("gang", 8'h0c, rd[7:0]);
      $display("test individual done");
   endtask
   task automatic t_gang;
      restart;
      cfg;
      bus(1'b1, pcg_pkg::ADDR_GANG, 8'h0d);
      pins(8'he0, 8'h0d, 8'h1f, 8'h02);
      bus(1'b0, pcg_pkg::ADDR_DATA, 8'h00);
      chk("data", 8'h45, rd[7:0]);
      bus(1'b1, pcg_pkg::ADDR_DRIVE, 8'h01);
      pins(8'he0, 8'h0d, 8'h1f, 8'h0d);
      bus(1'b1, pcg_pkg::ADDR_GANG, 8'h00);
      bus(1'b0, pcg_pkg::ADDR_GANG_STATUS, 8'h00);
      chk("lock", 8'h01, rd[15:8]);
      chk("mask", 8'h0c, rd[7:0]);
      bus(1'b0, pcg_pkg::ADDR_GANG, 8'h00);
      chk("gang", 8'h0d, rd[7:0]);
      $display("test gang done");
   endtask
   initial begin
      restart;
      t_reset;
      t_indiv;
      t_gang;
      stop_test;
   end
endmodule
`default_nettype wire
